// ### pkg/hpctl_cfg.svh
// Constants for the host port control block
`ifndef HPCTL_CFG_SVH
`define HPCTL_CFG_SVH
// Reset values
`define HPCTL_RST_ENABLE      1'b0
`define HPCTL_RST_IRQ_LEVEL   1'b1
// Sources for the interrupt pin
`define HPCTL_PIN_IRQ_IDLE    1'b1
// Time the ready output waits after a strobe before reporting ready again
`define HPCTL_BUSY_NS         8
`define HPCTL_CLK_NS          4
`define HPCTL_BUSY_CYCLES     ((`HPCTL_BUSY_NS + `HPCTL_CLK_NS - 1) / `HPCTL_CLK_NS)
`endif

// ### pkg/hpctl_pkg.sv
// Types shared by the host port control block
package hpctl_pkg;
    typedef enum logic {
        HPCTL_DIR_WRITE,
        HPCTL_DIR_READ
    } hpctl_dir_t;
    typedef enum logic [1:0] {
        HPCTL_ST_RESET,
        HPCTL_ST_IDLE,
        HPCTL_ST_BUSY
    } hpctl_state_t;
endpackage

// ### logic/hpctl_pin_drv.sv
// Output pin driver with emulation tri-state control
`timescale 1ns/100ps
`default_nettype none
module hpctl_pin_drv (
    input  wire logic clock_in,
    input  wire logic resetn_in,
    input  wire logic value_in,
    input  wire logic rst_value_in,
    input  wire logic off_n_in,
    output var  logic pin_out,
    output var  logic pin_oe_out
);
    logic pin_r;
    logic pin_nxt;
    logic oe_r;
    logic oe_nxt;

    // Drive enable drops whenever off_n_in is low
    always_comb begin
        pin_nxt = value_in;
        oe_nxt  = off_n_in;
    end

    // Register both so the pad sees glitch-free levels
    // Reset loads the pin's own idle level but keeps driving it, so the host
    // sees a defined level in reset; only the emulation disable floats the pad
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            pin_r <= rst_value_in;
            oe_r  <= off_n_in;
        end else begin
            pin_r <= pin_nxt;
            oe_r  <= oe_nxt;
        end
    end

    assign pin_out    = pin_r;
    assign pin_oe_out = oe_r;
endmodule
`default_nettype wire

// ### logic/hpctl_top.sv
// Host port pin control: strap, direction, ready and interrupt pins
//
// Behaviour
// - Ready high when the port can take the next transfer, else low.
// - Ready output floats while emulation disable and scan reset are both low.
// - Interrupt pin carries the interrupt request to the host.
// - Interrupt pin driven high while the chip is in reset.
// - With the port disabled, the pin may carry the timer 1 output.
// - Interrupt/timer pin floats while emulation disable and scan reset are both low.
// - Strap captured at reset release becomes the port-enable state.
// - Strap low or open at release disables the whole port.
// - Once disabled, strap changes are ignored until the next reset.
// - With scan reset low, emulation pin low floats the ready and interrupt pins.
`timescale 1ns/100ps
`default_nettype none
`include "hpctl_cfg.svh"
module hpctl_top (
    input  wire logic                  clock_in,
    input  wire logic                  resetn_in,
    input  wire logic                  host_port_enable_strap_in,
    input  wire hpctl_pkg::hpctl_dir_t host_read_not_write_in,
    input  wire logic                  host_strobe_in,
    input  wire logic                  core_busy_in,
    input  wire logic                  host_irq_req_in,
    input  wire logic                  timer1_sel_in,
    input  wire logic                  timer1_output_in,
    input  wire logic                  scan_reset_in,
    input  wire logic                  emulation_output_disable_in,
    output var  logic                  port_enabled_out,
    output var  logic                  xfer_read_out,
    output var  logic                  host_ready_out,
    output var  logic                  host_ready_oe_out,
    output var  logic                  host_interrupt_out,
    output var  logic                  host_interrupt_oe_out
);
    import hpctl_pkg::*;

    localparam logic [3:0] BUSY_CYC = 4'(`HPCTL_BUSY_CYCLES);

    // ****************************************************************
    // Strap capture and port state
    // ****************************************************************
    hpctl_state_t st_r;
    hpctl_state_t st_nxt;
    logic         en_r;
    logic         en_nxt;
    logic [3:0]   cnt_r;
    logic [3:0]   cnt_nxt;
    logic         dir_r;
    logic         dir_nxt;
    logic         off_n;
    logic         rdy_val;
    logic         irq_val;

    // Emulation disable only counts while scan reset is low
    assign off_n = scan_reset_in | emulation_output_disable_in;

    // First clocked cycle after release samples the strap exactly once
    always_comb begin
        st_nxt  = st_r;
        en_nxt  = en_r;
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        case (st_r)
            HPCTL_ST_RESET: begin
                en_nxt = host_port_enable_strap_in;
                st_nxt = HPCTL_ST_IDLE;
            end
            HPCTL_ST_IDLE: begin
                // Strap no longer sampled here, held until next reset
                if (en_r && host_strobe_in) begin
                    dir_nxt = (host_read_not_write_in == HPCTL_DIR_READ);
                    cnt_nxt = BUSY_CYC;
                    st_nxt  = HPCTL_ST_BUSY;
                end
            end
            HPCTL_ST_BUSY: begin
                if (cnt_r > 4'h1) begin
                    cnt_nxt = cnt_r - 4'h1;
                end else if (!core_busy_in) begin
                    cnt_nxt = 4'h0;
                    st_nxt  = HPCTL_ST_IDLE;
                end
            end
            default: begin
                st_nxt = HPCTL_ST_RESET;
            end
        endcase
    end

    // Sync reset: constants only, strap is taken afterwards
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            st_r  <= HPCTL_ST_RESET;
            en_r  <= `HPCTL_RST_ENABLE;
            cnt_r <= 4'h0;
            dir_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            en_r  <= en_nxt;
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            port_enabled_out <= 1'b0;
            xfer_read_out    <= 1'b0;
        end else begin
            port_enabled_out <= en_nxt;
            xfer_read_out    <= dir_nxt;
        end
    end

    // ****************************************************************
    // Pin values
    // ****************************************************************
    // Ready only when enabled, idle and core free; a disabled port never readies
    assign rdy_val = en_nxt && (st_nxt == HPCTL_ST_IDLE) && !core_busy_in;

    // Timer path only allowed while the port is disabled
    always_comb begin
        if (st_nxt == HPCTL_ST_RESET) begin
            irq_val = `HPCTL_RST_IRQ_LEVEL;
        end else if (!en_nxt && timer1_sel_in) begin
            irq_val = timer1_output_in;
        end else if (en_nxt) begin
            irq_val = ~host_irq_req_in;
        end else begin
            irq_val = `HPCTL_PIN_IRQ_IDLE;
        end
    end

    hpctl_pin_drv u_rdy (
        .clock_in     (clock_in),
        .resetn_in    (resetn_in),
        .value_in     (rdy_val),
        .rst_value_in (1'b0),
        .off_n_in     (off_n),
        .pin_out      (host_ready_out),
        .pin_oe_out   (host_ready_oe_out)
    );

    hpctl_pin_drv u_irq (
        .clock_in     (clock_in),
        .resetn_in    (resetn_in),
        .value_in     (irq_val),
        .rst_value_in (1'b1),
        .off_n_in     (off_n),
        .pin_out      (host_interrupt_out),
        .pin_oe_out   (host_interrupt_oe_out)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    sequence s_release;
        $rose(resetn_in);
    endsequence

    // Strobe accepted: port idle, enabled and the host strobing
    sequence s_strobe_taken;
        st_r == HPCTL_ST_IDLE && en_r && host_strobe_in;
    endsequence

    // Last busy cycle with the core free, so ready must come back next
    sequence s_busy_done;
        st_r == HPCTL_ST_BUSY && cnt_r <= 4'h1 && !core_busy_in;
    endsequence

    // Strap capture and hold
    a_strap_capture: assert property (
        s_release |=> port_enabled_out == $past(host_port_enable_strap_in))
        else $error("strap not captured at release");
    a_strap_hold: assert property (st_r != HPCTL_ST_RESET |=> $stable(en_r))
        else $error("enable changed after capture");

    // Reset levels; these must not be switched off by reset itself
    a_irq_reset: assert property (
        disable iff (1'b0) !resetn_in |=> host_interrupt_out)
        else $error("interrupt low in reset");
    a_irq_oe_reset: assert property (
        disable iff (1'b0) !resetn_in && off_n |=> host_interrupt_oe_out)
        else $error("interrupt not driven in reset");
    a_rdy_reset: assert property (
        disable iff (1'b0) !resetn_in |=> !host_ready_out)
        else $error("ready high in reset");

    // Output disable, one edge late because the enables are registered
    a_rdy_off: assert property (!off_n |=> !host_ready_oe_out)
        else $error("ready driven during disable");
    a_irq_off: assert property (!off_n |=> !host_interrupt_oe_out)
        else $error("interrupt driven during disable");
    a_pins_drive: assert property (
        off_n |=> host_ready_oe_out && host_interrupt_oe_out)
        else $error("pins floating without disable");

    // Ready pacing through a transfer
    a_disabled_rdy: assert property (
        !port_enabled_out && st_r != HPCTL_ST_RESET |=> !host_ready_out)
        else $error("ready from disabled port");
    a_busy_rdy: assert property (
        st_r == HPCTL_ST_BUSY && cnt_r > 4'h1 |=> !host_ready_out)
        else $error("ready while busy");
    a_core_busy: assert property (core_busy_in |=> !host_ready_out)
        else $error("ready while core busy");
    a_xfer_busy: assert property (s_strobe_taken |=> !host_ready_out)
        else $error("ready kept after strobe");
    a_rdy_return: assert property (s_busy_done |=> host_ready_out)
        else $error("ready not returned");
    a_dir_cap: assert property (
        s_strobe_taken |=> xfer_read_out == $past(host_read_not_write_in))
        else $error("direction not captured");

    // Interrupt pin sources
    a_irq_request: assert property (
        en_r && st_r != HPCTL_ST_RESET && host_irq_req_in |=> !host_interrupt_out)
        else $error("interrupt request not shown");
    a_irq_timer: assert property (
        en_r == 1'b0 && st_r == HPCTL_ST_IDLE && timer1_sel_in
            |=> host_interrupt_out == $past(timer1_output_in))
        else $error("timer not routed");
endmodule
`default_nettype wire

// ### dv/hpctl_host_model.sv
// Host bus model that issues port transfers
`timescale 1ns/100ps
`default_nettype none
module hpctl_host_model (
    input  wire logic                  clock_in,
    input  wire logic                  ready_in,
    output var  logic                  strobe_out,
    output var  hpctl_pkg::hpctl_dir_t dir_out,
    output var  logic                  host_port_select_n_out,
    output var  logic                  host_register_select_0_out,
    output var  logic                  host_register_select_1_out
);
    import hpctl_pkg::*;
    // Idle bus at time zero
    initial begin
        strobe_out = 1'b0;
        dir_out = HPCTL_DIR_WRITE;
        host_port_select_n_out = 1'b1;
        host_register_select_0_out = 1'b0;
        host_register_select_1_out = 1'b0;
    end
    // One transfer; ok is low if ready never returns
    task automatic xfer(input hpctl_dir_t d, input logic [1:0] r, output logic ok);
        int n;
        @(negedge clock_in);
        host_port_select_n_out = 1'b0;
        host_register_select_0_out = r[0];
        host_register_select_1_out = r[1];
        dir_out = d;
        strobe_out = 1'b1;
        @(negedge clock_in);
        strobe_out = 1'b0;
        ok = 1'b0;
        for (n = 0; n < 10 && !ok; n++) begin
            @(negedge clock_in);
            ok = (ready_in === 1'b1);
        end
        // Select held for the whole access, dropped only after the answer
        host_port_select_n_out = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### dv/hpctl_top_test.sv
// Self-checking bench for the host port control block
`timescale 1ns/100ps
`default_nettype none
module hpctl_top_test;
    import hpctl_pkg::*;
    logic       clock_in = 1'b0;
    logic       resetn_in = 1'b0;
    logic       host_port_enable_strap_in = 1'b1;
    hpctl_dir_t host_read_not_write_in;
    logic       host_strobe_in;
    logic       core_busy_in = 1'b0;
    logic       host_irq_req_in = 1'b0;
    logic       timer1_sel_in = 1'b0;
    logic       timer1_output_in = 1'b0;
    logic       scan_reset_in = 1'b1;
    logic       emulation_output_disable_in = 1'b1;
    logic       port_enabled_out, xfer_read_out, host_ready_out;
    logic       host_ready_oe_out, host_interrupt_out, host_interrupt_oe_out;
    logic       ok;
    int         n_errors = 0;
    int         num_checks = 0;

    hpctl_top u_dut (
        .clock_in                    (clock_in),
        .resetn_in                   (resetn_in),
        .host_port_enable_strap_in   (host_port_enable_strap_in),
        .host_read_not_write_in      (host_read_not_write_in),
        .host_strobe_in              (host_strobe_in),
        .core_busy_in                (core_busy_in),
        .host_irq_req_in             (host_irq_req_in),
        .timer1_sel_in               (timer1_sel_in),
        .timer1_output_in            (timer1_output_in),
        .scan_reset_in               (scan_reset_in),
        .emulation_output_disable_in (emulation_output_disable_in),
        .port_enabled_out            (port_enabled_out),
        .xfer_read_out               (xfer_read_out),
        .host_ready_out              (host_ready_out),
        .host_ready_oe_out           (host_ready_oe_out),
        .host_interrupt_out          (host_interrupt_out),
        .host_interrupt_oe_out       (host_interrupt_oe_out)
    );
    // Select and register choice have no pins on this block
    hpctl_host_model u_host (
        .clock_in                   (clock_in),
        .ready_in                   (host_ready_out),
        .strobe_out                 (host_strobe_in),
        .dir_out                    (host_read_not_write_in),
        .host_port_select_n_out     (),
        .host_register_select_0_out (),
        .host_register_select_1_out ()
    );

    // 250 MHz core clock
    initial begin
        forever #2 clock_in = ~clock_in;
    end

    task automatic chk(input logic got, input logic exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic do_reset(input logic s);
        @(negedge clock_in);
        resetn_in = 1'b0;
        host_port_enable_strap_in = s;
        repeat (10) @(negedge clock_in);
        chk(host_interrupt_out, 1'b1, "irq idle in reset");
        chk(host_interrupt_oe_out, 1'b1, "irq driven in reset");
        chk(host_ready_out, 1'b0, "ready low in reset");
        resetn_in = 1'b1;
        repeat (2) @(negedge clock_in);
        chk(port_enabled_out, s, "enable capture");
    endtask

    // Read then a write stalled by the core
    task automatic t_xfer;
        do_reset(1'b1);
        host_port_enable_strap_in = 1'b0;
        u_host.xfer(HPCTL_DIR_READ, 2'h0, ok);
        chk(ok, 1'b1, "ready after read");
        chk(xfer_read_out, 1'b1, "read dir");
        // Core turns busy on the strobe's own cycle, so the strobe is taken but ready never returns
        fork
            u_host.xfer(HPCTL_DIR_WRITE, 2'h1, ok);
            begin
                @(negedge clock_in);
                core_busy_in = 1'b1;
            end
        join
        chk(ok, 1'b0, "ready held by busy");
        chk(xfer_read_out, 1'b0, "write dir");
        core_busy_in = 1'b0;
        repeat (4) @(negedge clock_in);
        chk(host_ready_out, 1'b1, "ready back");
        chk(port_enabled_out, 1'b1, "enable kept");
    endtask

    // Timer selected but driven against the request: an enabled port ignores it
    task automatic t_irq;
        host_irq_req_in = 1'b1;
        timer1_sel_in = 1'b1;
        timer1_output_in = 1'b1;
        repeat (2) @(negedge clock_in);
        chk(host_interrupt_out, 1'b0, "irq asserted");
        host_irq_req_in = 1'b0;
        timer1_output_in = 1'b0;
        repeat (2) @(negedge clock_in);
        chk(host_interrupt_out, 1'b1, "irq released");
        timer1_sel_in = 1'b0;
    endtask

    // Disable only counts while scan reset is low
    task automatic t_off;
        emulation_output_disable_in = 1'b0;
        repeat (2) @(negedge clock_in);
        chk(host_ready_oe_out, 1'b1, "scan high keeps drive");
        scan_reset_in = 1'b0;
        repeat (2) @(negedge clock_in);
        chk(host_ready_oe_out, 1'b0, "ready floats");
        chk(host_interrupt_oe_out, 1'b0, "irq floats");
        emulation_output_disable_in = 1'b1;
        repeat (2) @(negedge clock_in);
        chk(host_interrupt_oe_out, 1'b1, "drive back");
    endtask

    task automatic t_dis;
        do_reset(1'b0);
        host_port_enable_strap_in = 1'b1;
        timer1_sel_in = 1'b1;
        repeat (3) @(negedge clock_in);
        chk(port_enabled_out, 1'b0, "strap ignored when off");
        chk(host_ready_out, 1'b0, "disabled never ready");
        chk(host_interrupt_out, 1'b0, "timer low");
        timer1_output_in = 1'b1;
        repeat (2) @(negedge clock_in);
        chk(host_interrupt_out, 1'b1, "timer high");
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        t_xfer;
        t_irq;
        t_off;
        t_dis;
        conclude;
    end
endmodule
`default_nettype wire
